// file: src/rgbps_step_regs.sv
// Pattern step registers, soft reset and the step sequencer with colour fades.
// Assumes a same-clock register port from the two-wire host slave and that
// curve_log and seq_run come from logic on sys_clk.
//
// Functional notes
// - Eight steps, each two 8-bit read-write registers, all bits clear on reset.
// - Red code is bits 7..5 of word A.
// - Green code is bits 4..2 of word A.
// - Blue code is bits 5..3 of word B.
// - Linear curve: codes give 0,7,14,21,32,46,71,100 percent of full scale.
// - Log curve: codes give 0,1,2,4,10,21,46,100 percent of full scale.
// - Execution time code: A bits 1..0 high, B bits 7..6 low.
// - Step lasts 197 ms for code 0 up to 3146 ms for code 15.
// - Fade time code in B bits 2..0: immediate, then 55 up to 3539 ms.
// - Any write to address 60h resets the whole device.
`timescale 1ns/1ps
`include "rgbps_regs.svh"

module rgbps_step_regs
  import rgbps_pkg::*;
#(
  parameter int TICK_CYCLES = `RGBPS_MS_NS / `RGBPS_CLK_PERIOD_NS
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic curve_log,
  input wire logic seq_run,
  output logic [6:0] red_pct,
  output logic [6:0] green_pct,
  output logic [6:0] blue_pct,
  output logic [2:0] cur_step,
  output logic soft_reset_req
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536)
  begin : g_bad_tick
    $error("TICK_CYCLES must lie between one and the tick counter range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and storage

  rgbps_word_a_t word_a [8];
  rgbps_word_b_t word_b [8];
  logic clr;
  wire hit_a = reg_addr[7:3] == 5'(`RGBPS_STEP_A_BASE >> 3);
  wire hit_b = reg_addr[7:3] == 5'(`RGBPS_STEP_B_BASE >> 3);
  wire hit_rst = reg_addr == `RGBPS_SOFT_RESET_ADDR;
  wire [2:0] idx = reg_addr[2:0];
  wire [7:0] next_rdata = hit_a ? word_a[idx] : hit_b ? word_b[idx] : 8'h00;

  assign clr = !rstn || soft_reset_req;

  always_ff @(posedge sys_clk)
  begin
    soft_reset_req <= rstn && reg_wr && hit_rst;
    reg_rdata <= clr ? 8'h00 : next_rdata;
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_step
    always_ff @(posedge sys_clk)
    begin
      if (clr)
      begin
        word_a[i] <= `RGBPS_STEP_REG_RESET;
        word_b[i] <= `RGBPS_STEP_REG_RESET;
      end
      else if (reg_wr && idx == 3'(i))
      begin
        if (hit_a)
          word_a[i] <= reg_wdata;
        if (hit_b)
          word_b[i] <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step field decode

  wire rgbps_word_a_t cur_a = word_a[cur_step];
  wire rgbps_word_b_t cur_b = word_b[cur_step];
  wire [3:0] exec_code = {cur_a.exec_hi, cur_b.exec_lo};
  wire [191:0] exec_tab = `RGBPS_EXEC_MS;
  wire [11:0] exec_ms = exec_tab[12 * int'(exec_code) +: 12];
  wire [95:0] fade_tab = `RGBPS_FADE_MS;
  wire [11:0] fade_ms = fade_tab[12 * int'(cur_b.fade_time_code) +: 12];
  wire [55:0] pct_tab = curve_log ? `RGBPS_LOG_PCT : `RGBPS_LIN_PCT;
  wire [2:0] code [3];
  assign code[0] = cur_a.red;
  assign code[1] = cur_a.green;
  assign code[2] = cur_b.blue;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  rgbps_state_t state;
  logic [15:0] tick_cnt;
  logic [11:0] step_ms;
  logic [6:0] prev [3];
  logic [6:0] level [3];
  logic [6:0] next_level [3];
  wire tick = tick_cnt == 16'(TICK_CYCLES - 1);
  wire step_done = tick && (13'(step_ms) + 13'h1 >= 13'(exec_ms));
  wire fade_done = step_ms >= fade_ms;

  always_ff @(posedge sys_clk)
  begin
    if (clr || state == RGBPS_IDLE || tick)
      tick_cnt <= 16'h0;
    else
      tick_cnt <= tick_cnt + 16'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (clr || !seq_run)
    begin
      state <= RGBPS_IDLE;
      cur_step <= 3'h0;
      step_ms <= 12'h0;
    end
    else
    begin
      case (state)
        RGBPS_IDLE:
        begin
          state <= RGBPS_FADE;
          step_ms <= 12'h0;
        end
        RGBPS_FADE, RGBPS_HOLD:
        begin
          if (step_done)
          begin
            cur_step <= cur_step + 3'h1;
            step_ms <= 12'h0;
            state <= RGBPS_FADE;
          end
          else
          begin
            if (tick)
              step_ms <= step_ms + 12'h1;
            if (state == RGBPS_FADE && fade_done)
              state <= RGBPS_HOLD;
          end
        end
        default:
          state <= RGBPS_IDLE;
      endcase
    end
  end

  for (genvar c = 0; c < 3; c++)
  begin : g_chan
    wire [6:0] tgt = pct_tab[7 * int'(code[c]) +: 7];
    wire signed [7:0] diff = $signed({1'b0, tgt}) - $signed({1'b0, prev[c]});
    wire signed [20:0] prod = diff * $signed({1'b0, step_ms});
    wire signed [20:0] quot = prod / $signed({9'h0, fade_ms});
    wire [6:0] ramp = 7'(prev[c] + 7'(quot));
    assign next_level[c] = (state == RGBPS_FADE && !fade_done) ? ramp :
                           (state == RGBPS_IDLE) ? 7'h0 : tgt;

    always_ff @(posedge sys_clk)
    begin
      if (clr)
      begin
        prev[c] <= 7'h0;
        level[c] <= 7'h0;
      end
      else
      begin
        level[c] <= next_level[c];
        if (state == RGBPS_IDLE || step_done)
          prev[c] <= next_level[c];
      end
    end
  end

  assign red_pct = level[0];
  assign green_pct = level[1];
  assign blue_pct = level[2];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  wire [6:0] pct_red_ref = pct_tab[7 * int'(cur_a.red) +: 7];
  wire [6:0] pct_grn_ref = pct_tab[7 * int'(cur_a.green) +: 7];
  wire [6:0] pct_blu_ref = pct_tab[7 * int'(cur_b.blue) +: 7];

  property p_soft_clear;
    @(posedge sys_clk) disable iff (!rstn)
    reg_wr && reg_addr == `RGBPS_SOFT_RESET_ADDR |=> soft_reset_req ##1
      (word_a[0] == 8'h00 && word_b[7] == 8'h00 && state == RGBPS_IDLE);
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset did not clear");

  property p_write_store;
    @(posedge sys_clk) disable iff (!rstn)
    reg_wr && reg_addr == `RGBPS_STEP_A_BASE && !soft_reset_req |=> word_a[0] == $past(reg_wdata);
  endproperty
  a_write_store: assert property (p_write_store) else $error("word A not stored");

  property p_red_hold;
    @(posedge sys_clk) disable iff (!rstn)
    state == RGBPS_HOLD && $stable(cur_step) && $stable(curve_log) && $past(state) == RGBPS_HOLD
      |-> red_pct == $past(pct_red_ref);
  endproperty
  a_red_hold: assert property (p_red_hold) else $error("red level mismatch");

  property p_green_hold;
    @(posedge sys_clk) disable iff (!rstn)
    state == RGBPS_HOLD && $stable(cur_step) && $stable(curve_log) && $past(state) == RGBPS_HOLD
      |-> green_pct == $past(pct_grn_ref);
  endproperty
  a_green_hold: assert property (p_green_hold) else $error("green level mismatch");

  property p_blue_hold;
    @(posedge sys_clk) disable iff (!rstn)
    state == RGBPS_HOLD && $stable(cur_step) && $stable(curve_log) && $past(state) == RGBPS_HOLD
      |-> blue_pct == $past(pct_blu_ref);
  endproperty
  a_blue_hold: assert property (p_blue_hold) else $error("blue level mismatch");

  property p_lin_value;
    @(posedge sys_clk) disable iff (!rstn)
    state == RGBPS_HOLD && !curve_log && cur_a.red == 3'h5 && !step_done
      |=> red_pct == 7'h2e;
  endproperty
  a_lin_value: assert property (p_lin_value) else $error("linear 101 not 46 percent");

  property p_log_value;
    @(posedge sys_clk) disable iff (!rstn)
    state == RGBPS_HOLD && curve_log && cur_a.red == 3'h4 && !step_done
      |=> red_pct == 7'h0a;
  endproperty
  a_log_value: assert property (p_log_value) else $error("log 100 not 10 percent");

  property p_step_length;
    @(posedge sys_clk) disable iff (!rstn || soft_reset_req)
    state != RGBPS_IDLE && seq_run && cur_step != $past(cur_step)
      |-> $past(step_ms) + 12'h1 == $past(exec_ms);
  endproperty
  a_step_length: assert property (p_step_length) else $error("step ended early or late");

  property p_fade_instant;
    @(posedge sys_clk) disable iff (!rstn)
    state == RGBPS_FADE && cur_b.fade_time_code == 3'h0 && seq_run && !step_done
      |=> state == RGBPS_HOLD;
  endproperty
  a_fade_instant: assert property (p_fade_instant) else $error("zero fade not immediate");

  property p_hold_after_fade;
    @(posedge sys_clk) disable iff (!rstn)
    state == RGBPS_HOLD |-> step_ms >= fade_ms;
  endproperty
  a_hold_after_fade: assert property (p_hold_after_fade) else $error("hold before fade end");

  c_fade_to_hold: cover property (@(posedge sys_clk) state == RGBPS_FADE ##1 state == RGBPS_HOLD);
  c_step_wrap: cover property (@(posedge sys_clk) cur_step == 3'h7 ##1 cur_step == 3'h0);
  c_soft_reset: cover property (@(posedge sys_clk) soft_reset_req);
  c_log_hold: cover property (@(posedge sys_clk) curve_log && state == RGBPS_HOLD);

endmodule // rgbps_step_regs

// file: src/rgbps_regs.svh
// Register map, tables and timing constants of the RGB pattern step store.
// Assumes a byte-wide internal register port behind the two-wire host link.
`ifndef RGBPS_REGS_SVH
`define RGBPS_REGS_SVH

`define RGBPS_SOFT_RESET_ADDR 8'h60
`define RGBPS_STEP_A_BASE 8'h50
`define RGBPS_STEP_B_BASE 8'h58
`define RGBPS_STEP_REG_RESET 8'h00

// Clock period and millisecond timebase
`define RGBPS_CLK_PERIOD_NS 40
`define RGBPS_MS_NS 1000000

// Intensity percent per code, code 0 in the low seven bits
`define RGBPS_LIN_PCT {7'h64, 7'h47, 7'h2e, 7'h20, 7'h15, 7'h0e, 7'h07, 7'h00}
`define RGBPS_LOG_PCT {7'h64, 7'h2e, 7'h15, 7'h0a, 7'h04, 7'h02, 7'h01, 7'h00}

// Step execution time in ms per code, code 0 lowest
`define RGBPS_EXEC_MS {12'hc4a, 12'hb85, 12'hac1, 12'h9fc, 12'h937, 12'h873, 12'h7ae, \
  12'h6e9, 12'h625, 12'h560, 12'h49c, 12'h3d7, 12'h312, 12'h24e, 12'h189, 12'h0c5}

// Colour transition time in ms per code, code 0 lowest
`define RGBPS_FADE_MS {12'hdd3, 12'h6ea, 12'h375, 12'h1ba, 12'h0dd, 12'h06e, 12'h037, 12'h000}

`endif

// file: src/rgbps_pkg.sv
// Types of the RGB pattern step store: register layouts and sequencer states.
// Assumes nothing of its surroundings.
package rgbps_pkg;

  typedef struct packed {
    logic [2:0] red;
    logic [2:0] green;
    logic [1:0] exec_hi;
  } rgbps_word_a_t;

  typedef struct packed {
    logic [1:0] exec_lo;
    logic [2:0] blue;
    logic [2:0] fade_time_code;
  } rgbps_word_b_t;

  typedef enum logic [1:0] {
    RGBPS_IDLE = 2'b00,
    RGBPS_FADE = 2'b01,
    RGBPS_HOLD = 2'b10
  } rgbps_state_t;

endpackage

// file: dv/test_rgbps_step_regs.sv
// Self-checking bench for the RGB pattern step store.
// Assumes the step store is driven directly on its register and sequencer ports.
`timescale 1ns/1ps

module test_rgbps_step_regs;
  import rgbps_pkg::*;
  localparam int TICK = 2;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic curve_log = 1'b0;
  logic seq_run = 1'b0;
  logic [7:0] reg_rdata;
  logic [6:0] red_pct;
  logic [6:0] green_pct;
  logic [6:0] blue_pct;
  logic [2:0] cur_step;
  logic soft_reset_req;
  int fails = 0;
  int total_checks = 0;
  logic [6:0] lin_tbl [8] = '{7'h00, 7'h07, 7'h0e, 7'h15, 7'h20, 7'h2e, 7'h47, 7'h64};
  logic [6:0] log_tbl [8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0a, 7'h15, 7'h2e, 7'h64};

  rgbps_step_regs #(.TICK_CYCLES(TICK)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .curve_log(curve_log), .seq_run(seq_run), .red_pct(red_pct), .green_pct(green_pct),
    .blue_pct(blue_pct), .cur_step(cur_step), .soft_reset_req(soft_reset_req));

  always #20 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_lvl(input logic [6:0] got, input logic [6:0] exp);
    chk_reg({1'b0, got}, {1'b0, exp});
  endtask

  task automatic chk_flag(input logic got);
    chk_reg({7'h00, got}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk) reg_addr <= a;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1 chk_reg(reg_rdata, exp);
  endtask

  task automatic wrap_up;
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    for (int i = 0; i < 16; i++)
      rd(8'h50 + 8'(i), 8'h00);
  endtask

  task automatic t_readback;
    for (int i = 0; i < 16; i++)
      wr(8'h50 + 8'(i), 8'ha5 ^ 8'(i * 19));
    for (int i = 0; i < 16; i++)
      rd(8'h50 + 8'(i), 8'ha5 ^ 8'(i * 19));
    rd(8'h60, 8'h00);
    rd(8'h4f, 8'h00);
  endtask

  task automatic t_curves;
    logic [2:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = 3'(i >> 1);
      wr(8'h50, {c, ~c, 2'b11});
      wr(8'h58, {2'b11, c ^ 3'h5, 3'h0});
      @(posedge sys_clk) {curve_log, seq_run} <= {i[0], 1'b1};
      repeat (4) @(posedge sys_clk);
      #1;
      chk_lvl(red_pct, i[0] ? log_tbl[c] : lin_tbl[c]);
      chk_lvl(green_pct, i[0] ? log_tbl[~c] : lin_tbl[~c]);
      chk_lvl(blue_pct, i[0] ? log_tbl[c ^ 3'h5] : lin_tbl[c ^ 3'h5]);
      @(posedge sys_clk) seq_run <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  task automatic t_step_time;
    int n;
    wr(8'h50, 8'h00);
    wr(8'h58, 8'h40);
    @(posedge sys_clk) {curve_log, seq_run} <= 2'b01;
    n = 0;
    while (cur_step === 3'h0 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
      #1;
    end
    chk_flag(n >= 393 * TICK - 4 && n <= 393 * TICK + 4);
    chk_reg({5'h00, cur_step}, 8'h01);
    @(posedge sys_clk) seq_run <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic t_fade;
    wr(8'h50, 8'he0);
    wr(8'h58, 8'hc1);
    @(posedge sys_clk) seq_run <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk_flag(red_pct < 7'h14);
    repeat (51) @(posedge sys_clk);
    #1 chk_flag(red_pct > 7'h23 && red_pct < 7'h41);
    repeat (65) @(posedge sys_clk);
    #1 chk_lvl(red_pct, 7'h64);
    chk_lvl(green_pct, 7'h00);
  endtask

  task automatic t_soft_reset;
    int hi;
    wr(8'h53, 8'h5a);
    wr(8'h5b, 8'h3c);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, 8'h60, 8'hff};
    @(posedge sys_clk) reg_wr <= 1'b0;
    hi = 0;
    for (int i = 0; i < 4; i++)
    begin
      #1 hi += int'(soft_reset_req === 1'b1);
      @(posedge sys_clk);
    end
    chk_reg(8'(hi), 8'h01);
    #1 chk_lvl(red_pct, 7'h00);
    rd(8'h53, 8'h00);
    rd(8'h5b, 8'h00);
    @(posedge sys_clk) seq_run <= 1'b0;
  endtask

  task automatic t_hard_reset;
    wr(8'h55, 8'h77);
    rd(8'h55, 8'h77);
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h55, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset_values();
    t_readback();
    t_curves();
    t_step_time();
    t_fade();
    t_soft_reset();
    t_hard_reset();
    wrap_up();
  end

  // Watchdog well beyond the expected run of roughly 1300 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
endmodule // test_rgbps_step_regs
